// ==== core/afm_mask_gate.sv ====
`timescale 1ns/1ps

module afm_mask_gate (
    afm_mask_if.gate mif // sources and masks in, raw summaries out
);
    import afm_pkg::*;

    byte_t alert_eff;
    byte_t fault_eff;
    byte_t alert_pass;
    byte_t fault_pass;

    ////////////////////////////////////////////////////////////////////////////
    // effective masks
    always_comb begin
        alert_eff = mif.alert_mask;
        // monitor input blocked from alert by either mask
        alert_eff[BIT_MONITOR] = mif.alert_mask[BIT_MONITOR] | mif.fault_mask[BIT_MONITOR];
        fault_eff = mif.fault_mask;
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-source gating
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_src
            // alert gating for output voltage, current, comm, monitor, power
            assign alert_pass[i] = mif.sources[i] & ~alert_eff[i] & MASK_VALID[i];
            // fault gating for the same source set
            assign fault_pass[i] = mif.sources[i] & ~fault_eff[i] & MASK_VALID[i];
        end
    endgenerate

    assign mif.alert_raw = |alert_pass;
    assign mif.fault_raw = |fault_pass;
endmodule

// ==== core/afm_regs.sv ====
// Function
// - Alert mask bits 7 and 6 block alerts from output voltage and current status.
// - Alert mask bit 3 blocks alerts from comm/memory/logic status.
// - Bit 2 of either mask blocks alerts from monitor input limit crossings.
// - Alert mask bit 0 blocks alerts from output power over its limit.
// - Fault mask is a read/write byte resetting to zero, all sources unmasked.
// - Fault mask bit 7 blocks faults from output voltage status.
// - Fault mask bit 6 blocks faults from output current status.
// - Fault mask bit 3 blocks faults from comm/memory/logic status.
// - Fault mask bit 0 blocks faults from output power over its limit.
// - General status bit 5 power-ok is legacy; hosts use status word bit 3.
// - Phase status bits 5, 4, 3 show phases 4, 3, 2 enabled.
// - Phase status bit 2 is one while power-save indicator is asserted.
`timescale 1ns/1ps

module afm_regs (
    input wire logic clk_in, // 200 MHz logic clock
    input wire logic rst_n_in, // async reset, active low
    input wire afm_pkg::byte_t reg_addr_in, // command code
    input wire logic reg_wr_in, // write strobe
    input wire afm_pkg::byte_t reg_wdata_in, // write data
    input wire logic reg_rd_in, // read strobe
    output logic [7:0] reg_rdata_out, // read data, registered
    output logic reg_rvalid_out, // read data valid pulse
    input wire logic voltage_status_any_in, // any output voltage status bit
    input wire logic current_status_any_in, // any output current status bit
    input wire logic comm_status_any_in, // any comm/memory/logic status bit
    input wire logic monitor_limit_in, // monitor input past high or low limit
    input wire logic power_limit_in, // output power past its limit
    input wire logic ready_in, // device ready
    input wire logic power_good_in, // legacy power good level
    input wire logic [2:0] phase_en_in, // phases 2, 3, 4 enabled
    input wire logic power_save_indicator_n_in, // power-save pin, active low
    output logic alert_out, // alert summary
    output logic fault_out // fault summary
);
    import afm_pkg::*;

    typedef struct packed {
        byte_t alert_mask;
        byte_t fault_mask;
        logic save_meta;
        logic save_sync;
        byte_t gen_status;
        byte_t phase_status;
        byte_t rdata;
        logic rvalid;
    } state_s;

    localparam state_s STATE_RESET = '{
        alert_mask: MASK_RESET,
        fault_mask: MASK_RESET,
        save_meta: SAVE_IDLE,
        save_sync: SAVE_IDLE,
        gen_status: STATUS_RESET,
        phase_status: STATUS_RESET,
        rdata: READ_ZERO,
        rvalid: 1'b0
    };

    state_s st_ff;
    state_s nxt_st;
    logic [SEL_W-1:0] sel;

    afm_mask_if mif ();

    afm_mask_gate u_gate (
        .mif(mif.gate)
    );

    ////////////////////////////////////////////////////////////////////////////
    // decode

    function automatic logic [SEL_W-1:0] reg_sel(input byte_t addr);
        logic [SEL_W-1:0] s;
        s = '0;
        s[SEL_ALERT] = (addr == ALERT_MASK_ADDR);
        s[SEL_FAULT] = (addr == FAULT_MASK_ADDR);
        s[SEL_GEN] = (addr == GEN_STATUS_ADDR);
        s[SEL_PHASE] = (addr == PHASE_STATUS_ADDR);
        return s;
    endfunction

    function automatic byte_t read_mux(input logic [SEL_W-1:0] s, input state_s cur);
        byte_t d;
        d = READ_ZERO;
        if (s[SEL_ALERT]) begin
            d = cur.alert_mask & MASK_VALID;
        end else if (s[SEL_FAULT]) begin
            d = cur.fault_mask & MASK_VALID;
        end else if (s[SEL_GEN]) begin
            d = cur.gen_status & GEN_VALID;
        end else if (s[SEL_PHASE]) begin
            d = cur.phase_status & PHASE_VALID;
        end
        return d;
    endfunction

    assign sel = reg_sel(reg_addr_in);

    ////////////////////////////////////////////////////////////////////////////
    // mask gate hookup

    always_comb begin
        mif.sources = STATUS_RESET;
        mif.sources[BIT_VOLTAGE] = voltage_status_any_in;
        mif.sources[BIT_CURRENT] = current_status_any_in;
        mif.sources[BIT_COMM] = comm_status_any_in;
        mif.sources[BIT_MONITOR] = monitor_limit_in;
        mif.sources[BIT_POWER] = power_limit_in;
    end

    assign mif.alert_mask = st_ff.alert_mask;
    assign mif.fault_mask = st_ff.fault_mask;

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        nxt_st = st_ff;
        nxt_st.save_meta = power_save_indicator_n_in;
        nxt_st.save_sync = st_ff.save_meta;
        if (reg_wr_in && sel[SEL_ALERT]) begin
            nxt_st.alert_mask = reg_wdata_in & MASK_VALID;
        end
        if (reg_wr_in && sel[SEL_FAULT]) begin
            nxt_st.fault_mask = reg_wdata_in & MASK_VALID;
        end
        // status bytes follow live state only, bus writes never reach them
        nxt_st.gen_status = STATUS_RESET;
        nxt_st.gen_status[GEN_FAULT] = mif.fault_raw;
        nxt_st.gen_status[GEN_ALERT] = mif.alert_raw;
        nxt_st.gen_status[GEN_PGOOD] = power_good_in;
        nxt_st.gen_status[GEN_READY] = ready_in;
        nxt_st.phase_status = STATUS_RESET;
        nxt_st.phase_status[PH_4] = phase_en_in[EN_PH4];
        nxt_st.phase_status[PH_3] = phase_en_in[EN_PH3];
        nxt_st.phase_status[PH_2] = phase_en_in[EN_PH2];
        nxt_st.phase_status[PH_SAVE] = ~st_ff.save_sync;
        nxt_st.rvalid = reg_rd_in;
        if (reg_rd_in) begin
            nxt_st.rdata = read_mux(sel, st_ff);
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_ff <= STATE_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata_out = st_ff.rdata;
    assign reg_rvalid_out = st_ff.rvalid;
    assign alert_out = st_ff.gen_status[GEN_ALERT];
    assign fault_out = st_ff.gen_status[GEN_FAULT];

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    logic only_volt;
    logic only_curr;
    logic only_comm;
    logic only_mon;
    logic only_pwr;
    assign only_volt = voltage_status_any_in && !current_status_any_in && !comm_status_any_in
        && !monitor_limit_in && !power_limit_in;
    assign only_curr = !voltage_status_any_in && current_status_any_in && !comm_status_any_in
        && !monitor_limit_in && !power_limit_in;
    assign only_comm = !voltage_status_any_in && !current_status_any_in && comm_status_any_in
        && !monitor_limit_in && !power_limit_in;
    assign only_mon = !voltage_status_any_in && !current_status_any_in && !comm_status_any_in
        && monitor_limit_in && !power_limit_in;
    assign only_pwr = !voltage_status_any_in && !current_status_any_in && !comm_status_any_in
        && !monitor_limit_in && power_limit_in;

    a_alert_vi_mask: assert property (
        ((only_volt && st_ff.alert_mask[BIT_VOLTAGE]) || (only_curr && st_ff.alert_mask[BIT_CURRENT]))
        |=> !alert_out)
        else $error("alert raised by masked voltage or current source");

    a_alert_volt_open: assert property (
        (only_volt && !st_ff.alert_mask[BIT_VOLTAGE]) |=> alert_out)
        else $error("unmasked voltage source gave no alert");

    a_alert_comm_mask: assert property (
        (only_comm && st_ff.alert_mask[BIT_COMM]) |=> !alert_out)
        else $error("alert raised by masked comm source");

    a_alert_monitor_mask: assert property (
        only_mon |=> (alert_out == !($past(st_ff.alert_mask[BIT_MONITOR]) || $past(st_ff.fault_mask[BIT_MONITOR]))))
        else $error("monitor alert not gated by either mask bit 2");

    a_alert_power_mask: assert property (
        only_pwr |=> (alert_out == !$past(st_ff.alert_mask[BIT_POWER])))
        else $error("power alert gating wrong");

    // write, one idle cycle, then read back the same register
    a_fault_mask_rw: assert property (
        (reg_wr_in && sel[SEL_FAULT]) ##1 !reg_wr_in ##1 (reg_rd_in && !reg_wr_in && sel[SEL_FAULT])
        |=> reg_rvalid_out && (reg_rdata_out == ($past(reg_wdata_in, 3) & MASK_VALID)))
        else $error("fault mask readback mismatch");

    a_fault_vi_mask: assert property (
        (only_volt || only_curr) |=> (fault_out == !($past(only_volt) ? $past(st_ff.fault_mask[BIT_VOLTAGE])
            : $past(st_ff.fault_mask[BIT_CURRENT]))))
        else $error("fault gating for voltage or current wrong");

    a_fault_comm_power: assert property (
        (only_comm || only_pwr) |=> (fault_out == !($past(only_comm) ? $past(st_ff.fault_mask[BIT_COMM])
            : $past(st_ff.fault_mask[BIT_POWER]))))
        else $error("fault gating for comm or power wrong");

    a_gen_status_map: assert property (
        ##1 (st_ff.gen_status[GEN_READY] == $past(ready_in)) && (st_ff.gen_status[GEN_PGOOD] == $past(power_good_in))
            && ((st_ff.gen_status & ~GEN_VALID) == READ_ZERO))
        else $error("general status bits wrong");

    a_phase_map: assert property (
        ##1 (st_ff.phase_status[PH_4:PH_2] == $past(phase_en_in)) && ((st_ff.phase_status & ~PHASE_VALID) == READ_ZERO))
        else $error("phase enable bits wrong");

    a_save_sync: assert property (
        (!power_save_indicator_n_in [*3]) |=> st_ff.phase_status[PH_SAVE])
        else $error("power save not reported after sync");

    a_status_ro: assert property (
        (reg_wr_in && (sel[SEL_GEN] || sel[SEL_PHASE])) |=> $stable(st_ff.alert_mask) && $stable(st_ff.fault_mask))
        else $error("status write disturbed masks");

    c_alert_rise: cover property ($rose(alert_out));
    c_fault_rise: cover property ($rose(fault_out));
    c_phase_read: cover property (reg_rd_in && sel[SEL_PHASE] ##1 reg_rdata_out != READ_ZERO);
    c_save_seen: cover property ($rose(st_ff.phase_status[PH_SAVE]));
endmodule

// ==== inc/afm_mask_if.sv ====
`timescale 1ns/1ps

interface afm_mask_if;
    import afm_pkg::*;

    byte_t sources;
    byte_t alert_mask;
    byte_t fault_mask;
    logic alert_raw;
    logic fault_raw;

    modport gate (
        input sources,
        input alert_mask,
        input fault_mask,
        output alert_raw,
        output fault_raw
    );

    modport owner (
        output sources,
        output alert_mask,
        output fault_mask,
        input alert_raw,
        input fault_raw
    );
endinterface

// ==== inc/afm_pkg.sv ====
package afm_pkg;

    typedef logic [7:0] byte_t;

    ////////////////////////////////////////////////////////////////////////////
    // command codes
    localparam byte_t ALERT_MASK_ADDR = 8'hF9;
    localparam byte_t FAULT_MASK_ADDR = 8'hFA;
    localparam byte_t GEN_STATUS_ADDR = 8'hFB;
    localparam byte_t PHASE_STATUS_ADDR = 8'hFC;

    ////////////////////////////////////////////////////////////////////////////
    // reset values and implemented-bit masks
    localparam byte_t MASK_RESET = 8'h00;
    localparam byte_t STATUS_RESET = 8'h00;
    localparam byte_t READ_ZERO = 8'h00;
    localparam byte_t MASK_VALID = 8'hCD;
    localparam byte_t GEN_VALID = 8'hF0;
    localparam byte_t PHASE_VALID = 8'h3C;
    localparam logic SAVE_IDLE = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // mask and source bit positions
    localparam int BIT_VOLTAGE = 7;
    localparam int BIT_CURRENT = 6;
    localparam int BIT_COMM = 3;
    localparam int BIT_MONITOR = 2;
    localparam int BIT_POWER = 0;

    // general status bit positions
    localparam int GEN_FAULT = 7;
    localparam int GEN_ALERT = 6;
    localparam int GEN_PGOOD = 5;
    localparam int GEN_READY = 4;

    // phase status bit positions
    localparam int PH_4 = 5;
    localparam int PH_3 = 4;
    localparam int PH_2 = 3;
    localparam int PH_SAVE = 2;

    // phase enable input indices
    localparam int EN_PH2 = 0;
    localparam int EN_PH3 = 1;
    localparam int EN_PH4 = 2;

    // one-hot register select positions
    localparam int SEL_ALERT = 0;
    localparam int SEL_FAULT = 1;
    localparam int SEL_GEN = 2;
    localparam int SEL_PHASE = 3;
    localparam int SEL_W = 4;

endpackage

// ==== test/afm_source_model.sv ====
`timescale 1ns/1ps

module afm_source_model
    import afm_pkg::*;
(
    input wire logic clk_in, // bench clock
    input wire afm_pkg::byte_t src_req_in, // sources wanted, at mask bit positions
    input wire logic [2:0] phase_req_in, // phases 2, 3, 4 wanted
    input wire logic ready_req_in, // ready wanted
    input wire logic good_req_in, // power good wanted
    input wire logic save_req_in, // power-save wanted
    output logic voltage_status_out, // output voltage status level
    output logic current_status_out, // output current status level
    output logic comm_status_out, // comm/memory/logic status level
    output logic monitor_limit_out, // monitor input limit level
    output logic power_limit_out, // output power limit level
    output logic ready_out, // ready level
    output logic good_out, // power good level
    output logic [2:0] phase_out, // phase enables
    output logic save_n_out // power-save pin, active low
);
    byte_t src_q;
    logic [5:0] misc_q;

    ////////////////////////////////////////////////////////////////////////////
    // sample on rising edge, drive on falling edge, so no race with the bench
    always @(posedge clk_in) begin
        src_q <= src_req_in;
        misc_q <= {phase_req_in, ready_req_in, good_req_in, save_req_in};
    end

    always @(negedge clk_in) begin
        voltage_status_out <= src_q[BIT_VOLTAGE];
        current_status_out <= src_q[BIT_CURRENT];
        comm_status_out <= src_q[BIT_COMM];
        monitor_limit_out <= src_q[BIT_MONITOR];
        power_limit_out <= src_q[BIT_POWER];
        phase_out <= misc_q[5:3];
        ready_out <= misc_q[2];
        good_out <= misc_q[1];
        // pin is pulled low while power save is asked for
        save_n_out <= !misc_q[0];
    end
endmodule

// ==== test/tb_alert_fault_mask_status.sv ====
`timescale 1ns/1ps

module tb_alert_fault_mask_status;
    import afm_pkg::*;

    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    byte_t reg_addr_in = 8'h00;
    logic reg_wr_in = 1'b0;
    byte_t reg_wdata_in = 8'h00;
    logic reg_rd_in = 1'b0;
    logic [7:0] reg_rdata_out;
    logic reg_rvalid_out;
    logic alert_out;
    logic fault_out;
    byte_t src_req = 8'h00;
    logic [2:0] phase_req = 3'h0;
    logic ready_req = 1'b0;
    logic good_req = 1'b0;
    logic save_req = 1'b0;
    logic s_volt, s_curr, s_comm, s_mon, s_pwr, s_rdy, s_good, s_save_n;
    logic [2:0] s_phase;
    int failures = 0;
    int comparisons = 0;
    int pos [5] = '{BIT_VOLTAGE, BIT_CURRENT, BIT_COMM, BIT_MONITOR, BIT_POWER};

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        forever #2.5 clk_in = ~clk_in;
    end

    afm_source_model src_u (.clk_in(clk_in), .src_req_in(src_req), .phase_req_in(phase_req),
        .ready_req_in(ready_req), .good_req_in(good_req), .save_req_in(save_req),
        .voltage_status_out(s_volt), .current_status_out(s_curr), .comm_status_out(s_comm),
        .monitor_limit_out(s_mon), .power_limit_out(s_pwr), .ready_out(s_rdy), .good_out(s_good),
        .phase_out(s_phase), .save_n_out(s_save_n));

    afm_regs dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in),
        .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
        .voltage_status_any_in(s_volt), .current_status_any_in(s_curr), .comm_status_any_in(s_comm),
        .monitor_limit_in(s_mon), .power_limit_in(s_pwr), .ready_in(s_rdy), .power_good_in(s_good),
        .phase_en_in(s_phase), .power_save_indicator_n_in(s_save_n),
        .alert_out(alert_out), .fault_out(fault_out));

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        if (failures == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input byte_t seen, input byte_t exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input byte_t a, input byte_t d);
        @(negedge clk_in);
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        @(negedge clk_in);
        reg_wr_in = 1'b0;
        check("reg_rvalid_out", {7'h00, reg_rvalid_out}, 8'h00);
    endtask

    task automatic rd(input byte_t a, input byte_t e);
        @(negedge clk_in);
        reg_addr_in = a;
        reg_rd_in = 1'b1;
        @(negedge clk_in);
        reg_rd_in = 1'b0;
        check("reg_rvalid_out", {7'h00, reg_rvalid_out}, 8'h01);
        check("reg_rdata_out", reg_rdata_out, e);
    endtask

    task automatic settle();
        repeat (5) @(negedge clk_in);
    endtask

    task automatic flags(input logic al, input logic fl);
        check("alert_out", {7'h00, alert_out}, {7'h00, al});
        check("fault_out", {7'h00, fault_out}, {7'h00, fl});
        rd(GEN_STATUS_ADDR, {fl, al, 6'h00});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #20000;
        failures++;
        end_sim();
    end

    initial begin
        byte_t m;
        repeat (6) @(negedge clk_in);
        rst_n_in = 1'b1;
        rd(ALERT_MASK_ADDR, 8'h00);
        rd(FAULT_MASK_ADDR, 8'h00);
        rd(GEN_STATUS_ADDR, 8'h00);
        rd(PHASE_STATUS_ADDR, 8'h00);
        wr(FAULT_MASK_ADDR, 8'hFF);
        rd(FAULT_MASK_ADDR, 8'hCD);
        wr(ALERT_MASK_ADDR, 8'hFF);
        rd(ALERT_MASK_ADDR, 8'hCD);
        wr(8'h10, 8'hFF);
        rd(8'h10, 8'h00);
        @(negedge clk_in);
        rst_n_in = 1'b0;
        repeat (2) @(negedge clk_in);
        rst_n_in = 1'b1;
        rd(FAULT_MASK_ADDR, 8'h00);
        rd(ALERT_MASK_ADDR, 8'h00);
        for (int i = 0; i < 5; i++) begin
            m = 8'h01 << pos[i];
            src_req = m;
            settle();
            flags(1'b1, 1'b1);
            wr(ALERT_MASK_ADDR, m);
            settle();
            flags(1'b0, 1'b1);
            wr(FAULT_MASK_ADDR, m);
            settle();
            flags(1'b0, 1'b0);
            wr(ALERT_MASK_ADDR, 8'h00);
            settle();
            flags(pos[i] != BIT_MONITOR, 1'b0);
            wr(FAULT_MASK_ADDR, 8'h00);
            src_req = 8'h00;
            settle();
            flags(1'b0, 1'b0);
        end
        ready_req = 1'b1;
        good_req = 1'b1;
        settle();
        rd(GEN_STATUS_ADDR, 8'h30);
        for (int p = 0; p < 8; p++) begin
            phase_req = p[2:0];
            settle();
            rd(PHASE_STATUS_ADDR, {2'b00, p[2:0], 3'b000});
        end
        save_req = 1'b1;
        settle();
        rd(PHASE_STATUS_ADDR, 8'h3C);
        save_req = 1'b0;
        settle();
        rd(PHASE_STATUS_ADDR, 8'h38);
        wr(GEN_STATUS_ADDR, 8'hFF);
        wr(PHASE_STATUS_ADDR, 8'hFF);
        rd(GEN_STATUS_ADDR, 8'h30);
        rd(PHASE_STATUS_ADDR, 8'h38);
        end_sim();
    end
endmodule
